// ==== rtl/spm_device_end.sv ====
// Device end: frame receiver, parity check, monitor multiplexer and scratch registers.
//
// What this block does
// - Master sets bit 8 for odd parity.
// - Seven ones elsewhere means parity bit zero.
// - Four ones elsewhere means parity bit one.
// - Parity checked only when option enabled.
// - Parity option off: master sends bit 8 zero on writes.
// - First byte command/address/parity, second byte data.
// - Bits 7-5 select source, codes 000-011.
// - Codes 100-111 route I/O, supply, battery.
// - Bit 4 enables internal sense resistor.
// - Bit 3 gain/attenuation, only for I/O codes.
// - Monitor clears on reset, supply off, non-Normal.
// - Supply off: access ignored, register cleared.
// - Four scratch bytes at 001-100, reset zero.
// - Read-back returns register in low byte.
`timescale 1ns/10ps
`default_nettype none

module spm_device_end (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial link.
  spm_link_if.device link,
  // Device conditions.
  input wire logic parity_option_in,
  input wire logic can_supply_regulator_on_in,
  input wire logic normal_mode_in,
  // Monitor multiplexer controls.
  output logic monitor_source_sel_hi_out,
  output logic monitor_source_sel_mid_out,
  output logic monitor_source_sel_lo_out,
  output logic internal_sense_resistor_en_out,
  output logic io_attenuation_out,
  output logic [7:0] monitor_route_out,
  // Frame results.
  output logic write_accepted_out,
  output logic parity_error_out
);

  typedef struct packed {
    logic sclk_q;
    logic cs_b_q;
    logic [15:0] rx;
    logic [4:0] bits;
    logic [15:0] tx;
    logic [7:0] monitor;
    logic [3:0][7:0] scratch;
    logic [7:0] route;
    logic atten;
    logic wr_ok;
    logic par_err;
    logic last_par_err;
  } spm_dev_state_type;

  spm_dev_state_type state;
  spm_dev_state_type next_state;

  logic access_ok;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic parity_ok;
  logic [15:0] first_byte;
  logic [4:0] rd_addr;
  logic [4:0] wr_addr;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic [2:0] sel;
  logic rd_cmd_hit;
  logic wr_cmd_hit;
  logic rd_scratch_hit;
  logic wr_scratch_hit;
  logic [1:0] rd_slot;
  logic [1:0] wr_slot;
  logic [7:0] wr_byte;
  logic monitor_write;
  logic [7:0] next_monitor;
  logic [7:0] route_dec;

  //////////////////////////////////////////////////////////////////////////////
  // Link event detection; link inputs are synchronous to clk_in.

  assign access_ok = can_supply_regulator_on_in & normal_mode_in;
  assign sclk_rise = link.sclk & ~state.sclk_q & ~link.cs_b;
  assign sclk_fall = ~link.sclk & state.sclk_q & ~link.cs_b;
  assign frame_start = state.cs_b_q & ~link.cs_b;
  assign frame_end = ~state.cs_b_q & link.cs_b & (state.bits == spm_pkg::FRAME_BITS);
  // The first byte sits in the low bits of the receiver; align it as a full frame.
  assign first_byte = {state.rx[7:0], spm_pkg::RESET_BYTE};
  assign rd_addr = first_byte[spm_pkg::ADDR_HI:spm_pkg::ADDR_LO];
  assign wr_addr = state.rx[spm_pkg::ADDR_HI:spm_pkg::ADDR_LO];
  // Odd count of ones over all sixteen bits, bit 8 included.
  assign parity_ok = ~parity_option_in | (^state.rx);
  assign status_byte = {state.last_par_err, can_supply_regulator_on_in, normal_mode_in,
                        spm_pkg::STATUS_PAD};

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // A read-back is recognised as soon as the first byte is in, so its answer
  // can be loaded on the eighth falling clock and still lead the second byte.
  assign rd_cmd_hit = (state.bits == spm_pkg::FIRST_BYTE_BITS)
      && (first_byte[spm_pkg::CMD_HI:spm_pkg::CMD_LO] == spm_pkg::CMD_READ_BACK)
      && first_byte[spm_pkg::PARITY_BIT];
  assign wr_cmd_hit = frame_end
      && (state.rx[spm_pkg::CMD_HI:spm_pkg::CMD_LO] == spm_pkg::CMD_WRITE);
  assign rd_scratch_hit = (rd_addr >= spm_pkg::ADDR_SCRATCH_A)
                          && (rd_addr <= spm_pkg::ADDR_SCRATCH_D);
  assign wr_scratch_hit = (wr_addr >= spm_pkg::ADDR_SCRATCH_A)
                          && (wr_addr <= spm_pkg::ADDR_SCRATCH_D);
  assign rd_slot = 2'(rd_addr - spm_pkg::ADDR_SCRATCH_A);
  assign wr_slot = 2'(wr_addr - spm_pkg::ADDR_SCRATCH_A);
  assign wr_byte = state.rx[spm_pkg::DATA_HI:spm_pkg::DATA_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Monitor multiplexer control.

  assign monitor_write = wr_cmd_hit && parity_ok && (wr_addr == spm_pkg::ADDR_MONITOR)
                         && access_ok;
  // Losing the CAN supply or leaving Normal wipes the setting, so an access
  // attempt in that condition also finds and leaves it cleared.
  assign next_monitor = !access_ok ? spm_pkg::RESET_BYTE
                      : monitor_write ? (wr_byte & spm_pkg::MONITOR_WRITABLE)
                      : state.monitor;
  assign sel = next_monitor[spm_pkg::SEL_HI:spm_pkg::SEL_LO];
  // One-hot route, bit n for select code n, so exactly one source line is active.
  for (genvar g = 0; g < spm_pkg::SOURCE_COUNT; g++) begin : g_route
    assign route_dec[g] = (sel == 3'(g));
  end

  always_comb begin
    rd_byte = spm_pkg::RESET_BYTE;
    if (rd_addr == spm_pkg::ADDR_MONITOR) begin
      // Held cleared while the supply is off, so a read there returns nothing.
      rd_byte = state.monitor;
    end else if (rd_scratch_hit) begin
      rd_byte = state.scratch[rd_slot];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_state = state;
    next_state.sclk_q = link.sclk;
    next_state.cs_b_q = link.cs_b;
    next_state.wr_ok = 1'b0;
    next_state.par_err = 1'b0;
    if (frame_start) begin
      next_state.bits = '0;
      next_state.tx = {status_byte, spm_pkg::RESET_BYTE};
    end else if (sclk_rise) begin
      next_state.rx = {state.rx[14:0], link.mosi};
      next_state.bits = 5'(state.bits + 5'h01);
    end else if (sclk_fall) begin
      if (rd_cmd_hit) begin
        next_state.tx = {rd_byte, spm_pkg::RESET_BYTE};
      end else begin
        next_state.tx = {state.tx[14:0], 1'b0};
      end
    end else if (wr_cmd_hit) begin
      next_state.last_par_err = ~parity_ok;
      if (!parity_ok) begin
        next_state.par_err = 1'b1;
      end else if (monitor_write) begin
        next_state.wr_ok = 1'b1;
      end else if (wr_scratch_hit) begin
        next_state.scratch[wr_slot] = wr_byte;
        next_state.wr_ok = 1'b1;
      end
    end
    next_state.monitor = next_monitor;
    next_state.route = route_dec;
    // Gain/attenuation only matters on the two I/O inputs.
    next_state.atten = next_monitor[spm_pkg::ATTEN_BIT]
                       & (sel == spm_pkg::SRC_IO0 || sel == spm_pkg::SRC_IO1);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= '0;
      state.sclk_q <= 1'b0;
      state.cs_b_q <= 1'b1;
      state.monitor <= spm_pkg::RESET_BYTE;
      state.route <= 8'h01;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign link.miso = state.tx[15];
  assign link.miso_oe = ~link.cs_b;
  assign monitor_source_sel_hi_out = state.monitor[spm_pkg::SEL_HI];
  assign monitor_source_sel_mid_out = state.monitor[spm_pkg::SEL_HI - 1];
  assign monitor_source_sel_lo_out = state.monitor[spm_pkg::SEL_LO];
  assign internal_sense_resistor_en_out = state.monitor[spm_pkg::RES_EN_BIT];
  assign io_attenuation_out = state.atten;
  assign monitor_route_out = state.route;
  assign write_accepted_out = state.wr_ok;
  assign parity_error_out = state.par_err;

endmodule : spm_device_end

`default_nettype wire

// ==== rtl/spm_pkg.sv ====
// Shared constants for the serial register link, its frame layout and register map.
package spm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Frame layout.
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FIRST_BYTE_BITS = 5'h08;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int PARITY_BIT = 8;
  localparam int SUB_ADDR_BIT = 7;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam logic [1:0] CMD_READ_BACK = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;

  //////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [4:0] ADDR_MONITOR = 5'h00;
  localparam logic [4:0] ADDR_SCRATCH_A = 5'h01;
  localparam logic [4:0] ADDR_SCRATCH_D = 5'h04;
  localparam int SCRATCH_COUNT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Monitor multiplexer register fields.
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int RES_EN_BIT = 4;
  localparam int ATTEN_BIT = 3;
  localparam logic [7:0] MONITOR_WRITABLE = 8'hF8;
  localparam int SOURCE_COUNT = 8;
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_REG_CURRENT = 3'h1;
  localparam logic [2:0] SRC_REFERENCE = 3'h2;
  localparam logic [2:0] SRC_TEMPERATURE = 3'h3;
  localparam logic [2:0] SRC_IO0 = 3'h4;
  localparam logic [2:0] SRC_IO1 = 3'h5;
  localparam logic [2:0] SRC_SUPPLY = 3'h6;
  localparam logic [2:0] SRC_BATTERY = 3'h7;

  //////////////////////////////////////////////////////////////////////////////
  // Status byte padding and serial clock pacing of the master.
  localparam logic [4:0] STATUS_PAD = 5'h00;
  localparam logic [2:0] SCLK_HALF_CYCLES = 3'h4;

endpackage : spm_pkg

// ==== rtl/spm_link_if.sv ====
// Serial link between the register device and its bus master.
`timescale 1ns/10ps
`default_nettype none

interface spm_link_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport device (
    input sclk,
    input cs_b,
    input mosi,
    output miso,
    output miso_oe
  );

  modport master (
    output sclk,
    output cs_b,
    output mosi,
    input miso,
    input miso_oe
  );
endinterface : spm_link_if

`default_nettype wire

// ==== rtl/spm_master_end.sv ====
// Master end: turns one user request into a 16-bit serial frame and returns the reply.
`timescale 1ns/10ps
`default_nettype none

module spm_master_end (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Serial link.
  spm_link_if.master link,
  // Request.
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_write_in,
  input wire logic [4:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  input wire logic parity_option_in,
  // Reply.
  output logic resp_valid_out,
  output logic [15:0] resp_data_out
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HIGH,
    ST_LOW,
    ST_TRAIL,
    ST_GAP
  } spm_mst_phase_type;

  typedef struct packed {
    spm_mst_phase_type phase;
    logic [2:0] div;
    logic [4:0] bits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic sclk;
    logic cs_b;
    logic resp_valid;
    logic [15:0] resp;
  } spm_mst_state_type;

  spm_mst_state_type state;
  spm_mst_state_type next_state;

  logic [15:0] frame;
  logic half_done;

  //////////////////////////////////////////////////////////////////////////////
  // Frame building.

  always_comb begin
    frame = '0;
    frame[spm_pkg::ADDR_HI:spm_pkg::ADDR_LO] = req_addr_in;
    if (req_write_in) begin
      frame[spm_pkg::CMD_HI:spm_pkg::CMD_LO] = spm_pkg::CMD_WRITE;
      frame[spm_pkg::DATA_HI:spm_pkg::DATA_LO] = req_data_in;
      // Bit 8 makes the total count odd; left zero when parity is off.
      frame[spm_pkg::PARITY_BIT] = parity_option_in & ~(^frame);
    end else begin
      frame[spm_pkg::CMD_HI:spm_pkg::CMD_LO] = spm_pkg::CMD_READ_BACK;
      frame[spm_pkg::PARITY_BIT] = 1'b1;
      frame[spm_pkg::SUB_ADDR_BIT] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer; each phase other than ST_IDLE lasts SCLK_HALF_CYCLES clocks.

  assign half_done = (state.div == 3'(spm_pkg::SCLK_HALF_CYCLES - 3'h1));

  always_comb begin
    next_state = state;
    next_state.resp_valid = 1'b0;
    next_state.div = half_done ? 3'h0 : 3'(state.div + 3'h1);
    case (state.phase)
      ST_IDLE: begin
        next_state.div = 3'h0;
        if (req_valid_in) begin
          next_state.tx = frame;
          next_state.bits = '0;
          next_state.cs_b = 1'b0;
          next_state.phase = ST_LEAD;
        end
      end
      ST_LEAD, ST_LOW: begin
        if (half_done) begin
          next_state.sclk = 1'b1;
          next_state.rx = {state.rx[14:0], link.miso};
          next_state.phase = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          next_state.sclk = 1'b0;
          next_state.bits = 5'(state.bits + 5'h01);
          if (state.bits == 5'(spm_pkg::FRAME_BITS - 5'h01)) begin
            next_state.phase = ST_TRAIL;
          end else begin
            next_state.tx = {state.tx[14:0], 1'b0};
            next_state.phase = ST_LOW;
          end
        end
      end
      ST_TRAIL: begin
        if (half_done) begin
          next_state.cs_b = 1'b1;
          next_state.resp_valid = 1'b1;
          next_state.resp = state.rx;
          next_state.phase = ST_GAP;
        end
      end
      ST_GAP: begin
        if (half_done) begin
          next_state.phase = ST_IDLE;
        end
      end
      default: begin
        next_state.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= '0;
      state.phase <= ST_IDLE;
      state.cs_b <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign req_ready_out = (state.phase == ST_IDLE);
  assign link.sclk = state.sclk;
  assign link.cs_b = state.cs_b;
  assign link.mosi = state.tx[15];
  assign resp_valid_out = state.resp_valid;
  assign resp_data_out = state.resp;

endmodule : spm_master_end

`default_nettype wire

// ==== verification/spm_link_asserts.sv ====
// Protocol checker for the serial link between the master and device ends.
`timescale 1ns/10ps
`default_nettype none

module spm_link_asserts (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Link signals.
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  //////////////////////////////////////////////////////////////////////////////
  sequence low_half;
    !sclk [*4];
  endsequence

  sequence high_half;
    sclk [*4];
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  oe_follow_a: assert property (miso_oe == !cs_b)
    else $error("miso enable differs from frame select");
  idle_clock_a: assert property (cs_b |-> !sclk)
    else $error("serial clock moved outside a frame");
  first_edge_a: assert property ($fell(cs_b) |-> low_half ##1 sclk)
    else $error("first clock rise not four cycles after select");
  high_time_a: assert property ($rose(sclk) |-> high_half ##1 !sclk)
    else $error("clock high phase not four cycles");
  low_time_a: assert property ($fell(sclk) && !cs_b |-> low_half)
    else $error("clock low phase shorter than four cycles");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("master data changed while clock high");
  frame_len_a: assert property ($fell(cs_b) |-> ##132 $rose(cs_b))
    else $error("frame select not 132 cycles long");
  frame_gap_a: assert property ($rose(cs_b) |-> cs_b [*5])
    else $error("gap between frames too short");
endmodule : spm_link_asserts

`default_nettype wire

// ==== verification/tb_spm_device_end.sv ====
// Self-checking bench joining the master end and the device end over the link.
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_spm_device_end;
  typedef struct {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;
    logic [15:0] f;} spm_row_type;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, m_par = 1'b1, d_par = 1'b1;
  logic can_on = 1'b1, normal = 1'b1;
  logic [4:0] req_addr = 5'h00;
  logic [7:0] req_data = 8'h00, route;
  logic req_ready, resp_valid, s_hi, s_mid, s_lo, res_en, att, w_acc, p_err;
  logic acc = 1'b0, perr = 1'b0, sclk_d = 1'b0;
  logic [15:0] sent = 16'h0000;
  logic [15:0] resp_data, resp;
  int fails = 0, num_checks = 0, cycles = 0;
  spm_row_type rows [10] = '{'{1'b1, 5'h01, 8'h5A, 8'h00, 16'h435A},
    '{1'b1, 5'h02, 8'hA5, 8'h00, 16'h45A5}, '{1'b1, 5'h03, 8'h40, 8'h00, 16'h4740},
    '{1'b1, 5'h04, 8'hFF, 8'h00, 16'h49FF}, '{1'b0, 5'h01, 8'h00, 8'h5A, 16'h0300},
    '{1'b0, 5'h02, 8'h00, 8'hA5, 16'h0500}, '{1'b0, 5'h03, 8'h00, 8'h40, 16'h0700},
    '{1'b0, 5'h04, 8'h00, 8'hFF, 16'h0900}, '{1'b1, 5'h00, 8'hFF, 8'h00, 16'h40FF},
    '{1'b0, 5'h00, 8'h00, 8'hF8, 16'h0100}};

  spm_link_if link ();
  spm_device_end spm_device_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
    .parity_option_in(d_par), .can_supply_regulator_on_in(can_on), .normal_mode_in(normal),
    .monitor_source_sel_hi_out(s_hi), .monitor_source_sel_mid_out(s_mid),
    .monitor_source_sel_lo_out(s_lo), .internal_sense_resistor_en_out(res_en),
    .io_attenuation_out(att), .monitor_route_out(route), .write_accepted_out(w_acc),
    .parity_error_out(p_err));
  spm_master_end spm_master_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_data_in(req_data), .parity_option_in(m_par),
    .resp_valid_out(resp_valid), .resp_data_out(resp_data));
  spm_link_asserts spm_link_asserts_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sclk(link.sclk), .cs_b(link.cs_b), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // The result pulses are single cycles, so they are caught into sticky flags.
  always @(posedge clk_in) begin
    cycles++;
    sclk_d <= link.sclk;
    if (link.sclk === 1'b1 && sclk_d === 1'b0) sent <= {sent[14:0], link.mosi};
    // Flags restart at the edge where the master takes a request, one set per frame.
    if (req_valid === 1'b1 && req_ready === 1'b1) begin
      acc <= 1'b0;
      perr <= 1'b0;
    end else begin
      if (w_acc === 1'b1) acc <= 1'b1;
      if (p_err === 1'b1) perr <= 1'b1;
    end
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // One frame; resp holds the reply, acc and perr the device's verdict on a write.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_data <= d;
    @(posedge clk_in);
    while (req_ready !== 1'b1) @(posedge clk_in);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_in);
      n++;
    end while (resp_valid !== 1'b1 && n < 300);
    if (n >= 300) fails++;
    resp = resp_data;
    repeat (6) @(posedge clk_in);
  endtask : xfer

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    `CHK(route, 8'h01)
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 5'(i), 8'h00);
      `CHK(resp[7:0], 8'h00)
    end
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      `CHK(resp[7:0], rows[i].e)
      `CHK(resp[15:8], 8'h60)
      `CHK(sent, rows[i].f)
      if (rows[i].w) `CHK(acc, 1'b1)
    end
    `CHK({s_hi, s_mid, s_lo, res_en, att, route}, {5'h1E, 8'h80})
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 5'h00, {3'(c), 5'h18});
      `CHK({s_hi, s_mid, s_lo, route}, {3'(c), 8'(1 << c)})
      `CHK({res_en, att}, {1'b1, (c == 4 || c == 5)})
    end
    xfer(1'b1, 5'h00, 8'h88);
    `CHK({res_en, att}, 2'h1)
    normal <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK({s_hi, s_mid, s_lo, att, route}, {4'h0, 8'h01})
    normal <= 1'b1;
    xfer(1'b1, 5'h00, 8'hB0);
    `CHK({res_en, att, route}, {2'h2, 8'h20})
    can_on <= 1'b0;
    xfer(1'b1, 5'h00, 8'hA0);
    `CHK({acc, res_en, route}, {2'h0, 8'h01})
    xfer(1'b0, 5'h00, 8'h00);
    `CHK({resp[7:0], route}, 16'h0001)
    can_on <= 1'b1;
    xfer(1'b1, 5'h03, 8'h69);
    `CHK({acc, perr}, 2'h2)
    `CHK(sent, 16'h4669)
    m_par <= 1'b0;
    xfer(1'b1, 5'h03, 8'h40);
    `CHK({acc, perr}, 2'h1)
    `CHK(sent, 16'h4640)
    xfer(1'b0, 5'h03, 8'h00);
    `CHK(resp[7:0], 8'h69)
    `CHK(resp[15:8], 8'hE0)
    d_par <= 1'b0;
    xfer(1'b1, 5'h03, 8'h40);
    `CHK({acc, perr}, 2'h2)
    rst_b_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    xfer(1'b0, 5'h03, 8'h00);
    `CHK(resp[7:0], 8'h00)
    summarize();
  end
endmodule : tb_spm_device_end

`default_nettype wire
